// ---- core/ucr_pkg.sv ----
// package for the usb control request handler
package ucr_pkg;
    // bus port
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATE  = 8'h04;
    localparam logic [7:0] REG_DADDR  = 8'h08;
    localparam logic [7:0] REG_DSCPTR = 8'h0c;
    localparam logic [7:0] REG_DSCDAT = 8'h10;
    localparam logic [7:0] REG_FEAT   = 8'h14;
    localparam logic [7:0] REG_EPST   = 8'h18;
    // ctrl register fields
    localparam int CTRL_PWRSEL = 0;
    localparam int CTRL_DLOAD  = 1;
    // request type recipients and direction
    localparam logic [7:0] RT_DEV = 8'h00;
    localparam logic [7:0] RT_IFC = 8'h01;
    localparam logic [7:0] RT_EP  = 8'h02;
    localparam logic [7:0] RT_IN  = 8'h80;
    // request codes
    localparam logic [7:0] RQ_GET_STATUS = 8'h00;
    localparam logic [7:0] RQ_CLR_FEAT   = 8'h01;
    localparam logic [7:0] RQ_SET_FEAT   = 8'h03;
    localparam logic [7:0] RQ_SET_ADDR   = 8'h05;
    localparam logic [7:0] RQ_GET_DESC   = 8'h06;
    localparam logic [7:0] RQ_SET_DESC   = 8'h07;
    localparam logic [7:0] RQ_GET_CFG    = 8'h08;
    localparam logic [7:0] RQ_SET_CFG    = 8'h09;
    localparam logic [7:0] RQ_GET_IFC    = 8'h0a;
    localparam logic [7:0] RQ_SET_IFC    = 8'h0b;
    localparam logic [7:0] RQ_ISO_DELAY  = 8'h31;
    // feature selectors
    localparam logic [15:0] FS_HALT   = 16'h0000;
    localparam logic [15:0] FS_RWAKE  = 16'h0001;
    localparam logic [15:0] FS_TEST   = 16'h0002;
    localparam logic [15:0] FS_U1     = 16'h0030;
    localparam logic [15:0] FS_U2     = 16'h0031;
    localparam logic [15:0] FS_LTM    = 16'h0032;
    // descriptor types
    localparam logic [7:0] DT_DEVICE = 8'h01;
    localparam logic [7:0] DT_CONFIG = 8'h02;
    localparam logic [7:0] DT_STRING = 8'h03;
    localparam logic [7:0] DT_QUAL   = 8'h06;
    localparam logic [7:0] DT_OSCFG  = 8'h07;
    localparam logic [7:0] DT_BOS    = 8'h0f;
    // endpoint indices
    localparam int NUM_IDX = 8;
    localparam logic [NUM_IDX-1:0] IDX_USED = 8'h9b;
    // descriptor memory
    localparam int DSC_WORDS = 128;
    typedef enum logic [1:0] {SPD_FS, SPD_HS, SPD_SS} ucr_speed_t;
    typedef struct packed {
        logic [7:0]  reqType;
        logic [7:0]  request;
        logic [15:0] value;
        logic [15:0] index;
        logic [15:0] length;
    } ucr_setup_t;
endpackage : ucr_pkg

// ---- core/ucr_ctrl_handler.sv ----
// control endpoint standard request handler
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
//Function
//- even index OUT, odd IN, number halved
//- fixed map; indices 2,5,6 unused
//- one config, interface, setting; no streams
//- bad request stalls, no pipe halt
//- 128x32 descriptor memory, loaded or written
//- recipient 00/01/02h; five valid endpoint values
//- usb2 clear feature wakeup, halt clears toggle
//- ss clear feature halt,u1,u2,ltm; seq reset
//- descriptor type from high byte, index zero except string
//- stall direct or wrong-speed descriptor requests
//- truncate long descriptor, short packet ends
//- ss status reports ltm/u1/u2, wakeup zero
//- self-powered bit from power method select
//- new address only after status stage
//- config 1 configured, 0 address state
//- valid set-config clears halts, toggles, seqs
//- bad interface errors, nonzero alternate stalls
//- set-descriptor always stalls
//- usb2 set feature wakeup, test, halt
//- function suspend options from wIndex high
//- no halt on endpoint 0
//- iso delay accepted in ss, else stall
module ucr_ctrl_handler
#(
    parameter int DSC_DEPTH = ucr_pkg::DSC_WORDS
)
(
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire logic                   setupValid,
    input  wire ucr_pkg::ucr_setup_t    setupPkt,
    input  wire ucr_pkg::ucr_speed_t    speedMode,
    input  wire logic                   statusDone,
    input  wire logic                   dataReq,
    input  wire logic                   loadWe,
    input  wire logic [6:0]             loadAddr,
    input  wire logic [31:0]            loadData,
    input  wire logic                   loadDone,
    input  wire logic [7:0]             regAddr,
    input  wire logic [31:0]            regWdata,
    input  wire logic                   regWr,
    input  wire logic                   regRd,
    output logic      [31:0]            regRdata,
    output logic                        stallOut,
    output logic                        ackOut,
    output logic      [31:0]            txData,
    output logic      [2:0]             txBytes,
    output logic                        txValid,
    output logic                        txLast,
    output logic      [6:0]             devAddr,
    output logic                        configured,
    output logic      [7:0]             epHalt,
    output logic      [7:0]             epToggleClr,
    output logic                        remoteWakeEn,
    output logic                        u1En,
    output logic                        u2En,
    output logic                        ltmEn,
    output logic                        funcSuspend,
    output logic                        funcWakeEn,
    output logic      [7:0]             testSel,
    output logic                        testModeEn
);
    import ucr_pkg::*;

    // direction in bit 0, number above
    function automatic logic [2:0] epIdx(input logic [7:0] a);
        epIdx = {a[1:0], a[7]};
    endfunction : epIdx

    function automatic logic epValid(input logic [7:0] a);
        epValid = IDX_USED[epIdx(a)] && (a[6:2] == 5'h00);
    endfunction : epValid

    logic [31:0] dscMem [DSC_DEPTH];
    logic [31:0] ctrl_ff;
    logic [6:0]  dscPtr_ff;
    logic        dscLoaded_ff;
    logic [6:0]  devAddr_ff;
    logic [6:0]  pendAddr_ff;
    logic        addrPend_ff;
    logic        cfg_ff;
    logic [7:0]  halt_ff;
    logic [7:0]  togClr_ff;
    logic        rwake_ff;
    logic        u1_ff;
    logic        u2_ff;
    logic        ltm_ff;
    logic        fsusp_ff;
    logic        fwake_ff;
    logic [7:0]  testSel_ff;
    logic        testEn_ff;
    logic        stall_ff;
    logic        ack_ff;
    logic [31:0] regRdata_ff;

    // descriptor streaming
    logic [6:0]  rdPtr_ff;
    logic [15:0] remain_ff;
    logic        inData_ff;
    logic [31:0] status_ff;
    logic        fromStat_ff;
    logic [31:0] txData_ff;
    logic [2:0]  txBytes_ff;
    logic        txValid_ff;
    logic        txLast_ff;

    ucr_setup_t  s;
    logic        isDev;
    logic        isIfc;
    logic        isEp;
    logic        ss;
    logic        okReq;
    logic        epSel;
    logic        dirIn;
    logic [15:0] dscLen;
    logic [6:0]  dscBase;
    logic [7:0]  dtype;

    always_comb
    begin
        s     = setupPkt;
        ss    = (speedMode == SPD_SS);
        dirIn = s.reqType[7];
        isDev = ((s.reqType & 8'h7f) == RT_DEV);
        isIfc = ((s.reqType & 8'h7f) == RT_IFC);
        isEp  = ((s.reqType & 8'h7f) == RT_EP);
        epSel = epValid(s.index[7:0])
                && (ss || s.index[15:8] == 8'h00);
        dtype = s.value[15:8];
        // directory word type>>1 holds {len, base}
        dscBase = 7'h00;
        dscLen  = 16'h0000;
        okReq   = 1'b0;
        unique case (s.request)
            RQ_GET_STATUS:
                okReq = dirIn && (isEp ? epSel : (isDev || isIfc) && s.index == 16'h0000);
            RQ_CLR_FEAT, RQ_SET_FEAT:
            begin
                if (isDev && !ss)
                    okReq = (s.value == FS_RWAKE && s.index == 16'h0000)
                         || (s.request == RQ_SET_FEAT && s.value == FS_TEST
                             && s.index[7:0] == 8'h00);
                else if (isDev)
                    okReq = (s.value == FS_U1 || s.value == FS_U2 || s.value == FS_LTM)
                         && s.index == 16'h0000;
                else if (isIfc)
                    okReq = ss && s.value == FS_HALT && s.index[7:0] == 8'h00;
                else if (isEp)
                    okReq = s.value == FS_HALT && epSel
                         && (s.request == RQ_CLR_FEAT
                             || epIdx(s.index[7:0]) > 3'd1);
                okReq = okReq && !dirIn;
            end
            RQ_SET_ADDR:  okReq = isDev && !dirIn && s.value[15:7] == 9'h000;
            RQ_GET_DESC:
            begin
                unique case (dtype)
                    DT_DEVICE, DT_CONFIG, DT_STRING: okReq = 1'b1;
                    DT_QUAL, DT_OSCFG: okReq = !ss;
                    DT_BOS:   okReq = ss;
                    default:  okReq = 1'b0;
                endcase
                okReq = okReq && isDev && dirIn && dscLoaded_ff
                     && (dtype == DT_STRING || s.value[7:0] == 8'h00);
                dscBase = dscMem[{4'h0, dtype[3:1]}][6:0];
                dscLen  = dscMem[{4'h0, dtype[3:1]}][31:16];
            end
            RQ_SET_DESC:  okReq = 1'b0;
            RQ_GET_CFG:   okReq = isDev && dirIn;
            RQ_SET_CFG:   okReq = isDev && !dirIn && s.value[15:1] == 15'h0000;
            RQ_GET_IFC:   okReq = isIfc && dirIn && s.index == 16'h0000 && cfg_ff;
            RQ_SET_IFC:   okReq = isIfc && !dirIn && s.index == 16'h0000
                               && s.value == 16'h0000;
            RQ_ISO_DELAY: okReq = ss && isDev && !dirIn;
            default:      okReq = 1'b0;
        endcase
    end

    // descriptor memory: load port or software writes
    always_ff @(posedge clk)
    begin
        if (loadWe)
            dscMem[loadAddr] <= loadData;
        else if (regWr && regAddr == REG_DSCDAT)
            dscMem[dscPtr_ff] <= regWdata;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            dscLoaded_ff <= 1'b0;
        else if (loadDone || (regWr && regAddr == REG_CTRL && regWdata[CTRL_DLOAD]))
            dscLoaded_ff <= 1'b1;
    end

    // software registers
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            ctrl_ff   <= 32'h0000_0000;
            dscPtr_ff <= 7'h00;
        end
        else if (regWr)
        begin
            if (regAddr == REG_CTRL)
                ctrl_ff <= {30'h0, regWdata[CTRL_DLOAD], regWdata[CTRL_PWRSEL]};
            if (regAddr == REG_DSCPTR)
                dscPtr_ff <= regWdata[6:0];
            else if (regAddr == REG_DSCDAT)
                dscPtr_ff <= dscPtr_ff + 7'h01;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            regRdata_ff <= 32'h0000_0000;
        else if (regRd)
        begin
            unique case (regAddr)
                REG_CTRL:   regRdata_ff <= ctrl_ff;
                REG_STATE:  regRdata_ff <= {20'h0, testEn_ff, fwake_ff, fsusp_ff, ltm_ff,
                                            u2_ff, u1_ff, rwake_ff, cfg_ff, dscLoaded_ff,
                                            addrPend_ff, 2'h0};
                REG_DADDR:  regRdata_ff <= {25'h0, devAddr_ff};
                REG_DSCPTR: regRdata_ff <= {25'h0, dscPtr_ff};
                REG_DSCDAT: regRdata_ff <= dscMem[dscPtr_ff];
                REG_FEAT:   regRdata_ff <= {24'h0, testSel_ff};
                REG_EPST:   regRdata_ff <= {24'h0, halt_ff};
                default:    regRdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // answer one cycle after the setup
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            stall_ff <= 1'b0;
            ack_ff   <= 1'b0;
        end
        else
        begin
            stall_ff <= setupValid && !okReq;
            ack_ff   <= setupValid && okReq;
        end
    end

    // address: held until status stage completes
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            devAddr_ff  <= 7'h00;
            pendAddr_ff <= 7'h00;
            addrPend_ff <= 1'b0;
        end
        else if (setupValid && okReq && s.request == RQ_SET_ADDR)
        begin
            pendAddr_ff <= s.value[6:0];
            addrPend_ff <= 1'b1;
        end
        else if (addrPend_ff && statusDone)
        begin
            devAddr_ff  <= pendAddr_ff;
            addrPend_ff <= 1'b0;
        end
    end

    // features applied at setup, before status
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            cfg_ff     <= 1'b0;
            rwake_ff   <= 1'b0;
            u1_ff      <= 1'b0;
            u2_ff      <= 1'b0;
            ltm_ff     <= 1'b0;
            fsusp_ff   <= 1'b0;
            fwake_ff   <= 1'b0;
            testSel_ff <= 8'h00;
            testEn_ff  <= 1'b0;
        end
        else if (setupValid && okReq)
        begin
            if (s.request == RQ_SET_CFG)
                cfg_ff <= s.value[0];
            if (isDev && (s.request == RQ_SET_FEAT || s.request == RQ_CLR_FEAT))
            begin
                unique case (s.value)
                    FS_RWAKE: rwake_ff <= (s.request == RQ_SET_FEAT);
                    FS_U1:    u1_ff    <= (s.request == RQ_SET_FEAT);
                    FS_U2:    u2_ff    <= (s.request == RQ_SET_FEAT);
                    FS_LTM:   ltm_ff   <= (s.request == RQ_SET_FEAT);
                    FS_TEST:
                    begin
                        testSel_ff <= s.index[15:8];
                        testEn_ff  <= 1'b1;
                    end
                    default:  ;
                endcase
            end
            if (isIfc && s.request == RQ_SET_FEAT)
            begin
                fsusp_ff <= s.index[8];
                fwake_ff <= s.index[9];
            end
            else if (isIfc && s.request == RQ_CLR_FEAT)
                fsusp_ff <= 1'b0;
        end
    end

    // halts and toggle/sequence resets
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            halt_ff   <= 8'h00;
            togClr_ff <= 8'h00;
        end
        else
        begin
            togClr_ff <= 8'h00;
            if (setupValid && okReq)
            begin
                if (s.request == RQ_SET_CFG || s.request == RQ_SET_IFC)
                begin
                    halt_ff   <= 8'h00;
                    togClr_ff <= IDX_USED;
                end
                else if (isEp && s.request == RQ_SET_FEAT)
                    halt_ff[epIdx(s.index[7:0])] <= 1'b1;
                else if (isEp && s.request == RQ_CLR_FEAT)
                begin
                    halt_ff[epIdx(s.index[7:0])]   <= 1'b0;
                    togClr_ff[epIdx(s.index[7:0])] <= 1'b1;
                end
            end
        end
    end

    // data stage source: status words or descriptor memory
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            inData_ff   <= 1'b0;
            remain_ff   <= 16'h0000;
            rdPtr_ff    <= 7'h00;
            status_ff   <= 32'h0000_0000;
            fromStat_ff <= 1'b0;
        end
        else if (setupValid)
        begin
            inData_ff   <= okReq && dirIn;
            fromStat_ff <= (s.request != RQ_GET_DESC);
            rdPtr_ff    <= dscBase;
            status_ff   <= 32'h0000_0000;
            remain_ff   <= (dscLen < s.length) ? dscLen : s.length;
            unique case (s.request)
                RQ_GET_CFG:
                begin
                    status_ff[0] <= cfg_ff;
                    remain_ff    <= (s.length == 16'h0) ? 16'h0 : 16'h1;
                end
                RQ_GET_IFC: remain_ff <= (s.length == 16'h0) ? 16'h0 : 16'h1;
                RQ_GET_STATUS:
                begin
                    remain_ff <= (s.length < 16'h2) ? s.length : 16'h2;
                    if (isDev)
                        status_ff[4:0] <= {ltm_ff && ss, u2_ff && ss, u1_ff && ss,
                                           rwake_ff && !ss, ctrl_ff[CTRL_PWRSEL]};
                    else if (isIfc)
                        status_ff[1:0] <= ss ? {fwake_ff, 1'b1} : 2'b00;
                    else
                        status_ff[0] <= halt_ff[epIdx(s.index[7:0])];
                end
                default: ;
            endcase
        end
        else if (inData_ff && dataReq)
        begin
            remain_ff <= (remain_ff > 16'h4) ? remain_ff - 16'h4 : 16'h0;
            rdPtr_ff  <= rdPtr_ff + 7'h01;
            if (remain_ff <= 16'h4)
                inData_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            txData_ff  <= 32'h0000_0000;
            txBytes_ff <= 3'h0;
            txValid_ff <= 1'b0;
            txLast_ff  <= 1'b0;
        end
        else
        begin
            txValid_ff <= inData_ff && dataReq;
            txData_ff  <= fromStat_ff ? status_ff : dscMem[rdPtr_ff];
            txBytes_ff <= (remain_ff > 16'h4) ? 3'h4 : remain_ff[2:0];
            // last word of four bytes or fewer, or zero length, closes the stage
            txLast_ff  <= inData_ff && dataReq && remain_ff <= 16'h4;
        end
    end

    assign regRdata     = regRdata_ff;
    assign stallOut     = stall_ff;
    assign ackOut       = ack_ff;
    assign txData       = txData_ff;
    assign txBytes      = txBytes_ff;
    assign txValid      = txValid_ff;
    assign txLast       = txLast_ff;
    assign devAddr      = devAddr_ff;
    assign configured   = cfg_ff;
    assign epHalt       = halt_ff;
    assign epToggleClr  = togClr_ff;
    assign remoteWakeEn = rwake_ff;
    assign u1En         = u1_ff;
    assign u2En         = u2_ff;
    assign ltmEn        = ltm_ff;
    assign funcSuspend  = fsusp_ff;
    assign funcWakeEn   = fwake_ff;
    assign testSel      = testSel_ff;
    assign testModeEn   = testEn_ff;
endmodule : ucr_ctrl_handler

// ---- bench/ucr_ctrl_handler_chk.sv ----
// concurrent checks for the control request handler
`timescale 1ns/1ps
module ucr_ctrl_handler_chk
(
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       setupValid,
    input wire logic       statusDone,
    input wire logic       dataReq,
    input wire logic       stallOut,
    input wire logic       ackOut,
    input wire logic       txValid,
    input wire logic [2:0] txBytes,
    input wire logic [6:0] devAddr,
    input wire logic       configured,
    input wire logic [7:0] epHalt,
    input wire logic [7:0] epToggleClr
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // exactly one verdict, so a silent drop fails too
    sequence answered;
        ackOut ^ stallOut;
    endsequence
    one_answer_a: assert property (setupValid |=> answered)
        else $error("setup not answered");
    no_spurious_a: assert property (ackOut || stallOut |-> $past(setupValid))
        else $error("answer without setup");
    addr_late_a: assert property ($changed(devAddr) |-> $past(statusDone))
        else $error("address moved before status");
    halt_map_a: assert property ((epHalt & 8'h67) == 8'h00)
        else $error("halt on control or unused index");
    halt_ack_a: assert property ($changed(epHalt) |-> ackOut)
        else $error("halt moved without accept");
    cfg_ack_a: assert property ($changed(configured) |-> ackOut)
        else $error("config moved without accept");
    toggle_ack_a: assert property (epToggleClr != 8'h00 |-> ackOut)
        else $error("toggle reset without accept");
    tx_word_a: assert property (txValid |-> $past(dataReq) && txBytes inside {[1:4]})
        else $error("data word out of turn");
endmodule : ucr_ctrl_handler_chk

bind ucr_ctrl_handler ucr_ctrl_handler_chk i_chk (.clk, .reset_n, .setupValid, .statusDone,
    .dataReq, .stallOut, .ackOut, .txValid, .txBytes, .devAddr, .configured, .epHalt,
    .epToggleClr);

// ---- bench/ucr_usb_host.sv ----
// host side model issuing control transfers
`timescale 1ns/1ps
module ucr_usb_host
(
    input wire logic            clk,
    input wire logic            stallOut,
    input wire logic            ackOut,
    input wire logic [31:0]     txData,
    input wire logic [2:0]      txBytes,
    input wire logic            txValid,
    input wire logic            txLast,
    output ucr_pkg::ucr_setup_t setupPkt,
    output logic                setupValid,
    output logic                statusDone,
    output logic                dataReq
);
    import ucr_pkg::*;
    logic        gotStall, acked, dataOk, lastSeen;
    logic [31:0] word0;
    logic [2:0]  lastBytes;
    int          nBytes;
    int          slow = 0;
    initial {setupPkt, setupValid, statusDone, dataReq} = '0;
    // no status stage after a stall, as a real host gives up there
    task automatic xfer(input ucr_setup_t pkt);
        @(posedge clk);
        setupValid <= 1'b1;
        setupPkt <= pkt;
        @(posedge clk);
        setupValid <= 1'b0;
        #1;
        gotStall = stallOut;
        acked = ackOut;
        dataOk = ackOut ^ stallOut;
        nBytes = 0;
        lastSeen = !(acked && pkt.reqType[7] && pkt.length != 16'h0);
        for (int k = 0; k < 40 && !lastSeen; k++)
        begin
            repeat (slow) @(posedge clk);
            @(posedge clk);
            dataReq <= 1'b1;
            @(posedge clk);
            dataReq <= 1'b0;
            #1;
            dataOk &= txValid;
            if (k == 0)
                word0 = txData;
            nBytes += int'(txBytes);
            lastBytes = txBytes;
            lastSeen = txLast;
        end
        dataOk &= lastSeen;
        if (acked)
        begin
            @(posedge clk);
            statusDone <= 1'b1;
            @(posedge clk);
            statusDone <= 1'b0;
            #1;
        end
    endtask : xfer
endmodule : ucr_usb_host

// ---- bench/testbench.sv ----
// self-checking bench for the control request handler
`timescale 1ns/1ps
`define CHECK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin n_fail++; \
    $display("mismatch %s expected %h seen %h", nm, ex, gt); end end
module testbench;
    import ucr_pkg::*;
    logic        clk = 1'b0, reset_n = 1'b0, loadWe = 1'b0, loadDone = 1'b0;
    logic        regWr = 1'b0, regRd = 1'b0;
    ucr_speed_t  speedMode = SPD_HS;
    logic [31:0] loadData = '0, regWdata = '0, regRdata, txData, rd;
    logic [2:0]  txBytes;
    logic        setupValid, statusDone, dataReq, stallOut, ackOut, txValid, txLast;
    logic        configured, remoteWakeEn, u1En, u2En, ltmEn, funcSuspend, funcWakeEn, testModeEn;
    logic [6:0]  devAddr, loadAddr = '0;
    logic [7:0]  epHalt, epToggleClr, testSel, togSeen, regAddr = '0;
    ucr_setup_t  setupPkt;
    ucr_setup_t  bad [11];
    int          n_fail = 0;
    int          comparisons = 0;
    always #25 clk = ~clk;
    always @(posedge clk) togSeen <= togSeen | epToggleClr;
    ucr_ctrl_handler i_dut (.clk, .reset_n, .setupValid, .setupPkt, .speedMode, .statusDone,
        .dataReq, .loadWe, .loadAddr, .loadData, .loadDone, .regAddr, .regWdata, .regWr,
        .regRd, .regRdata, .stallOut, .ackOut, .txData, .txBytes, .txValid, .txLast,
        .devAddr, .configured, .epHalt, .epToggleClr, .remoteWakeEn, .u1En, .u2En, .ltmEn,
        .funcSuspend, .funcWakeEn, .testSel, .testModeEn);
    ucr_usb_host i_host (.clk, .stallOut, .ackOut, .txData, .txBytes, .txValid, .txLast,
        .setupPkt, .setupValid, .statusDone, .dataReq);
    task automatic finish_test;
        if (n_fail == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        rd = regRdata;
    endtask : reg_rd
    task automatic req(input ucr_setup_t p, input logic st);
        i_host.xfer(p);
        `CHECK("stall", st, i_host.gotStall)
        `CHECK("handshake", 1'b1, i_host.dataOk)
    endtask : req
    initial
    begin
        togSeen = '0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        reg_rd(8'hfc);
        `CHECK("unmapped", 32'h0, rd)
        reg_wr(REG_CTRL, 32'h1);
        reg_rd(REG_CTRL);
        `CHECK("pwrsel", 1'b1, rd[0])
        req('{RT_IN, RQ_GET_STATUS, 16'h0, 16'h0, 16'h2}, 1'b0);
        `CHECK("selfpwr", 1'b1, i_host.word0[0])
        req('{RT_IN, RQ_GET_DESC, 16'h0100, 16'h0, 16'h8}, 1'b1);
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk);
            loadWe <= 1'b1;
            loadAddr <= (i == 0) ? 7'h00 : 7'h0f + 7'(i);
            loadData <= (i == 0) ? 32'h0012_0010 : 32'ha0a1_a2a3 + 32'(i);
        end
        @(posedge clk);
        loadWe <= 1'b0;
        loadDone <= 1'b1;
        @(posedge clk);
        loadDone <= 1'b0;
        req('{RT_IN, RQ_GET_DESC, 16'h0100, 16'h0, 16'h8}, 1'b0);
        `CHECK("trunc", 8, i_host.nBytes)
        `CHECK("descw", 32'ha0a1_a2a4, i_host.word0)
        i_host.slow = 2;
        req('{RT_IN, RQ_GET_DESC, 16'h0100, 16'h0, 16'h40}, 1'b0);
        `CHECK("short", 18, i_host.nBytes)
        `CHECK("tail", 3'd2, i_host.lastBytes)
        i_host.slow = 0;
        reg_wr(REG_DSCPTR, 32'h14);
        reg_rd(REG_DSCDAT);
        `CHECK("dscreg", 32'ha0a1_a2a8, rd)
        req('{RT_DEV, RQ_SET_ADDR, 16'h5, 16'h0, 16'h0}, 1'b0);
        `CHECK("addr", 7'h05, devAddr)
        req('{RT_DEV, RQ_SET_CFG, 16'h1, 16'h0, 16'h0}, 1'b0);
        `CHECK("cfg", 1'b1, configured)
        req('{RT_IN, RQ_GET_CFG, 16'h0, 16'h0, 16'h1}, 1'b0);
        `CHECK("getcfg", 8'h01, i_host.word0[7:0])
        req('{RT_EP, RQ_SET_FEAT, FS_HALT, 16'h81, 16'h0}, 1'b0);
        req('{RT_EP, RQ_SET_FEAT, FS_HALT, 16'h02, 16'h0}, 1'b0);
        req('{RT_EP, RQ_SET_FEAT, FS_HALT, 16'h83, 16'h0}, 1'b0);
        `CHECK("halts", 8'h98, epHalt)
        req('{RT_IN | RT_EP, RQ_GET_STATUS, 16'h0, 16'h81, 16'h2}, 1'b0);
        `CHECK("epstat", 1'b1, i_host.word0[0])
        togSeen = '0;
        req('{RT_EP, RQ_CLR_FEAT, FS_HALT, 16'h81, 16'h0}, 1'b0);
        `CHECK("clrhalt", 8'h90, epHalt)
        `CHECK("toggle", 8'h08, togSeen)
        req('{RT_IFC, RQ_SET_IFC, 16'h0, 16'h0, 16'h0}, 1'b0);
        `CHECK("ifcclr", 8'h00, epHalt)
        req('{RT_EP, RQ_SET_FEAT, FS_HALT, 16'h81, 16'h0}, 1'b0);
        togSeen = '0;
        req('{RT_DEV, RQ_SET_CFG, 16'h1, 16'h0, 16'h0}, 1'b0);
        `CHECK("cfgclr", 8'h00, epHalt)
        `CHECK("cfgtog", 8'h98, togSeen & 8'h98)
        bad = '{'{RT_DEV, RQ_SET_DESC, 16'h0100, 16'h0, 16'h0},
                '{RT_DEV, RQ_ISO_DELAY, 16'h0, 16'h0, 16'h0},
                '{RT_IFC, RQ_SET_IFC, 16'h1, 16'h0, 16'h0},
                '{RT_IFC, RQ_SET_IFC, 16'h0, 16'h1, 16'h0},
                '{RT_IN, RQ_GET_DESC, 16'h0101, 16'h0, 16'h8},
                '{RT_IN, RQ_GET_DESC, 16'h0400, 16'h0, 16'h8},
                '{RT_IN, RQ_GET_DESC, 16'h0f00, 16'h0, 16'h8},
                '{RT_EP, RQ_SET_FEAT, FS_HALT, 16'h0, 16'h0},
                '{RT_EP, RQ_SET_FEAT, FS_HALT, 16'h80, 16'h0},
                '{RT_DEV, RQ_CLR_FEAT, FS_U1, 16'h0, 16'h0},
                '{8'h83, RQ_GET_STATUS, 16'h0, 16'h0, 16'h2}};
        foreach (bad[i])
            req(bad[i], 1'b1);
        `CHECK("nohalt", 8'h00, epHalt)
        req('{RT_DEV, RQ_SET_FEAT, FS_RWAKE, 16'h0, 16'h0}, 1'b0);
        `CHECK("rwake", 1'b1, remoteWakeEn)
        @(posedge clk);
        speedMode <= SPD_SS;
        for (int s = 0; s < 3; s++)
            req('{RT_DEV, RQ_SET_FEAT, FS_U1 + 16'(s), 16'h0, 16'h0}, 1'b0);
        `CHECK("ssen", 3'b111, {ltmEn, u2En, u1En})
        req('{RT_IN, RQ_GET_STATUS, 16'h0, 16'h0, 16'h2}, 1'b0);
        `CHECK("ssstat", 5'h1d, i_host.word0[4:0])
        req('{RT_DEV, RQ_CLR_FEAT, FS_U1, 16'h0, 16'h0}, 1'b0);
        `CHECK("u1clr", 1'b0, u1En)
        req('{RT_IFC, RQ_SET_FEAT, FS_HALT, 16'h0300, 16'h0}, 1'b0);
        `CHECK("fsusp", 2'b11, {funcWakeEn, funcSuspend})
        req('{RT_EP, RQ_SET_FEAT, FS_HALT, 16'h83, 16'h0}, 1'b0);
        req('{RT_IN | RT_EP, RQ_GET_STATUS, 16'h0, 16'hff83, 16'h2}, 1'b0);
        `CHECK("sshalt", 1'b1, i_host.word0[0])
        togSeen = '0;
        req('{RT_EP, RQ_CLR_FEAT, FS_HALT, 16'h83, 16'h0}, 1'b0);
        `CHECK("seqclr", 8'h80, togSeen)
        req('{RT_DEV, RQ_ISO_DELAY, 16'h0, 16'h0, 16'h0}, 1'b0);
        @(posedge clk);
        speedMode <= SPD_HS;
        req('{RT_DEV, RQ_SET_FEAT, FS_TEST, 16'h0400, 16'h0}, 1'b0);
        `CHECK("test", 9'h104, {testModeEn, testSel})
        finish_test();
    end
endmodule : testbench
